// >>> hw/dsadc_pkg.sv
// Shared constants, phase encoding and carrier types for the converter sequencer.
package dsadc_pkg;

  localparam int unsigned OSC_DIV        = 4;     // Oscillator clocks per count clock.
  localparam int unsigned INTEG_COUNTS   = 1000;  // Signal accumulate length.
  localparam int unsigned RUNDOWN_MAX    = 2000;  // Longest reference rundown.
  localparam int unsigned NULL_MIN       = 1000;  // Shortest offset-null.
  localparam int unsigned CYCLE_COUNTS   = 4000;  // Whole measurement cycle.
  localparam int unsigned BP_DIV         = 800;   // Oscillator clocks per backplane period.
  localparam int unsigned BP_HALF        = BP_DIV / 2;
  localparam int unsigned FULL_SCALE     = 1999;  // Largest displayable reading.

  localparam logic [6:0]  SEG_ALL_ON     = 7'h7f;
  localparam logic [3:0]  BCD_NINE       = 4'h9;

  // Measurement phases in their fixed order.
  typedef enum logic [1:0] {
    PH_NULL,
    PH_ACCUM,
    PH_RUNDOWN
  } phase_type;

  // Analog switch network controls.
  typedef struct packed {
    logic inputs_short;    // Both inputs shorted to analog common.
    logic ref_charge;      // Reference capacitor charging.
    logic null_loop;       // Offset feedback loop closed.
    logic inputs_connect;  // External inputs connected.
    logic low_to_common;   // Low input tied to analog common.
    logic ref_pos;         // Reference applied with positive polarity.
    logic ref_neg;         // Reference applied with negative polarity.
  } switch_type;

  // Latched reading: sign, thousands flag and three decimal digits.
  typedef struct packed {
    logic       negative;
    logic       thousand;
    logic [3:0] hundreds;
    logic [3:0] tens;
    logic [3:0] units;
  } reading_type;

  // Segment order is {g,f,e,d,c,b,a}.
  typedef struct packed {
    logic       sign_seg;
    logic       thousands_seg;
    logic [6:0] hundreds_seg;
    logic [6:0] tens_seg;
    logic [6:0] units_seg;
  } segments_type;

endpackage

// >>> hw/dsadc_seq.sv
// Dual-slope converter sequencer with display latch and segment drive.
`timescale 1ns/100ps
module dsadc_seq
  import dsadc_pkg::*;
#(
  parameter bit LCD_VARIANT = 1'b1  // One for liquid-crystal panel, zero for LED.
)(
  input  wire logic        mclk_in,                 // Oscillator clock, four pulses per tick.
  input  wire logic        reset_in,                // Synchronous reset, active high.
  input  wire logic        comparator_in,           // High while integrator is above zero.
  input  wire logic        reading_freeze_input,    // Hold: high freezes the display.
  input  wire logic        display_check_in,        // High forces all segments on.
  output switch_type       switches_out,            // Analog switch controls.
  output phase_type        phase_out,               // Current measurement phase.
  output logic             reference_rundown_phase, // High during rundown.
  output logic             panel_common_drive,      // Backplane square wave.
  output logic             sign_indicator_output,   // Minus indicator drive.
  output logic             thousands_one_segments,  // Both segments of the leading one.
  output logic      [6:0]  hundreds_seg_out,        // Hundreds digit segments.
  output logic      [6:0]  tens_seg_out,            // Tens digit segments.
  output logic      [6:0]  units_seg_out            // Units digit segments.
);

  //////////////////////////////////////////////////////////////////////////////
  // Count clock prescaler and phase counters.

  // The oscillator source (external, crystal or RC) lives outside; all three
  // arrive here as the single mclk_in, so no mode selection is needed.

  logic [1:0]  presc_r;
  logic [1:0]  presc_nxt;
  logic        tick;
  phase_type   phase_r;
  phase_type   phase_nxt;
  logic [11:0] phase_cnt_r;      // Count clocks spent in the present phase.
  logic [11:0] phase_cnt_nxt;
  logic [11:0] cycle_cnt_r;      // Count clocks spent in the present cycle.
  logic [11:0] cycle_cnt_nxt;
  logic        sign_r;           // Sign captured at end of accumulate.
  logic        sign_nxt;
  logic        zero_cross;
  logic        accum_done;
  logic        rundown_done;
  logic        cycle_done;

  localparam logic [1:0]  PRESC_LAST = 2'(OSC_DIV - 1);
  localparam logic [11:0] ACCUM_LAST = 12'(INTEG_COUNTS - 1);
  localparam logic [11:0] RUN_MAX    = 12'(RUNDOWN_MAX);
  localparam logic [11:0] CYC_LAST   = 12'(CYCLE_COUNTS - 1);
  localparam logic [11:0] NULL_FLOOR = 12'(NULL_MIN);

  // One tick every fourth oscillator clock clocks the decimal counters.
  assign tick      = (presc_r == PRESC_LAST);
  assign presc_nxt = tick ? 2'h0 : presc_r + 2'h1;

  // Integrator returned to zero when comparator differs from captured sign.
  assign zero_cross   = (comparator_in != sign_r);
  assign accum_done   = tick && (phase_r == PH_ACCUM) && (phase_cnt_r == ACCUM_LAST);
  // Rundown stops on zero crossing or at its 2000-count limit.
  assign rundown_done = tick && (phase_r == PH_RUNDOWN) &&
                        (zero_cross || (phase_cnt_r == RUN_MAX - 12'h1));
  // The cycle closes at a fixed 4000 counts, so null takes the remainder.
  assign cycle_done   = tick && (cycle_cnt_r == CYC_LAST);

  // Next-state selection for the three-phase sequence.
  always_comb begin
    phase_nxt     = phase_r;
    phase_cnt_nxt = phase_cnt_r;
    sign_nxt      = sign_r;
    cycle_cnt_nxt = cycle_cnt_r;
    if (tick) begin
      phase_cnt_nxt = phase_cnt_r + 12'h1;
      cycle_cnt_nxt = cycle_done ? 12'h0 : cycle_cnt_r + 12'h1;
      case (phase_r)
        PH_NULL: begin
          if (cycle_done) begin
            phase_nxt     = PH_ACCUM;
            phase_cnt_nxt = 12'h0;
          end
        end
        PH_ACCUM: begin
          if (accum_done) begin
            phase_nxt     = PH_RUNDOWN;
            phase_cnt_nxt = 12'h0;
            sign_nxt      = comparator_in; // Sign sampled at end of accumulate.
          end
        end
        PH_RUNDOWN: begin
          if (rundown_done) begin
            phase_nxt     = PH_NULL;
            phase_cnt_nxt = 12'h0;
          end
        end
        default: begin
          phase_nxt     = PH_NULL;
          phase_cnt_nxt = 12'h0;
        end
      endcase
    end
  end

  // Sequencer state; hold and display check never reach this path.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      presc_r     <= 2'h0;
      phase_r     <= PH_NULL;
      phase_cnt_r <= NULL_FLOOR;
      cycle_cnt_r <= 12'(CYCLE_COUNTS - NULL_MIN);
      sign_r      <= 1'b0;
    end else begin
      presc_r     <= presc_nxt;
      phase_r     <= phase_nxt;
      phase_cnt_r <= phase_cnt_nxt;
      cycle_cnt_r <= cycle_cnt_nxt;
      sign_r      <= sign_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Analog switch controls.

  switch_type sw_nxt;

  // Switch settings follow the phase that is about to start.
  always_comb begin
    sw_nxt = '0;
    case (phase_nxt)
      PH_NULL: begin
        sw_nxt.inputs_short = 1'b1;
        sw_nxt.ref_charge   = 1'b1;
        sw_nxt.null_loop    = 1'b1;
      end
      PH_ACCUM: begin
        sw_nxt.inputs_connect = 1'b1; // Loop open, short removed.
      end
      PH_RUNDOWN: begin
        sw_nxt.low_to_common = 1'b1;
        sw_nxt.ref_pos       = !sign_nxt; // Oppose the accumulated charge.
        sw_nxt.ref_neg       = sign_nxt;
      end
      default: sw_nxt = '0;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      switches_out            <= '0;
      phase_out               <= PH_NULL;
      reference_rundown_phase <= 1'b0;
    end else begin
      switches_out            <= sw_nxt;
      phase_out               <= phase_nxt;
      reference_rundown_phase <= (phase_nxt == PH_RUNDOWN);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Rundown counter in decimal digits and the display latch.

  logic [3:0]  bcd_r [3];
  logic [3:0]  bcd_nxt [3];
  logic        thou_r;
  logic        thou_nxt;
  logic [3:0]  carry;
  reading_type latch_r;
  logic        load_latch;

  // A decade chain counts rundown ticks, so the reading is the count itself.
  assign carry[0] = tick && (phase_r == PH_RUNDOWN);
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_decade
      assign carry[gi+1]  = carry[gi] && (bcd_r[gi] == BCD_NINE);
      assign bcd_nxt[gi]  = accum_done ? 4'h0 :
                            carry[gi] ? ((bcd_r[gi] == BCD_NINE) ? 4'h0 : bcd_r[gi] + 4'h1) :
                            bcd_r[gi];
      always_ff @(posedge mclk_in) begin
        if (reset_in) begin
          bcd_r[gi] <= 4'h0;
        end else begin
          bcd_r[gi] <= bcd_nxt[gi];
        end
      end
    end
  endgenerate

  // The thousands place only ever shows one, capping the reading at 1999.
  assign thou_nxt = accum_done ? 1'b0 : (thou_r | carry[3]);

  // Load once per cycle at rundown end, skipped while hold is high.
  assign load_latch = rundown_done && !reading_freeze_input;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      thou_r  <= 1'b0;
      latch_r <= '0;
    end else begin
      thou_r <= thou_nxt;
      if (load_latch) begin
        latch_r.negative <= !sign_r; // Negative input drives comparator low.
        latch_r.thousand <= thou_r;
        latch_r.hundreds <= bcd_r[2];
        latch_r.tens     <= bcd_r[1];
        latch_r.units    <= bcd_r[0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Segment decode, backplane and panel drive.

  segments_type dec;
  segments_type lit;
  logic [8:0]   bp_cnt_r;
  logic         bp_r;
  logic         bp_flip;

  localparam logic [8:0] BP_LAST = 9'(BP_HALF - 1);

  seg_decode u_dec_hundreds (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .digit_in (latch_r.hundreds),
    .seg_out  (dec.hundreds_seg)
  );
  seg_decode u_dec_tens (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .digit_in (latch_r.tens),
    .seg_out  (dec.tens_seg)
  );
  seg_decode u_dec_units (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .digit_in (latch_r.units),
    .seg_out  (dec.units_seg)
  );

  // Thousands is one output covering both segments of a one.
  assign dec.thousands_seg = latch_r.thousand;
  assign dec.sign_seg      = latch_r.negative;

  // Display check overrides only the lit pattern, showing minus and 1888.
  assign lit = display_check_in ? '1 : dec;

  // Backplane toggles every 400 oscillator clocks: a period of 800.
  assign bp_flip = (bp_cnt_r == BP_LAST);

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      bp_cnt_r <= 9'h0;
      bp_r     <= 1'b0;
    end else begin
      bp_cnt_r <= bp_flip ? 9'h0 : bp_cnt_r + 9'h1;
      bp_r     <= bp_flip ? !bp_r : bp_r;
    end
  end

  // LCD: segment equals backplane when off, inverse when lit.
  // LED: no backplane; segment output high means sink current.
  segments_type drive;
  assign drive = LCD_VARIANT ? (lit ^ {$bits(segments_type){bp_r}}) : lit;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      panel_common_drive     <= 1'b0;
      sign_indicator_output  <= 1'b0;
      thousands_one_segments <= 1'b0;
      hundreds_seg_out       <= 7'h00;
      tens_seg_out           <= 7'h00;
      units_seg_out          <= 7'h00;
    end else begin
      panel_common_drive     <= LCD_VARIANT ? bp_r : 1'b0;
      sign_indicator_output  <= drive.sign_seg;
      thousands_one_segments <= drive.thousands_seg;
      hundreds_seg_out       <= drive.hundreds_seg;
      tens_seg_out           <= drive.tens_seg;
      units_seg_out          <= drive.units_seg;
    end
  end

endmodule

// >>> hw/seg_decode.sv
// Registered BCD to seven-segment decoder for one digit.
`timescale 1ns/100ps
module seg_decode
  import dsadc_pkg::*;
(
  input  wire logic       mclk_in,     // System clock.
  input  wire logic       reset_in,    // Synchronous reset, active high.
  input  wire logic [3:0] digit_in,    // Decimal digit 0 to 9.
  output logic      [6:0] seg_out      // Pattern {g,f,e,d,c,b,a}, high is lit.
);

  logic [6:0] pattern;

  // Conventional patterns; codes above nine blank the digit.
  always_comb begin
    case (digit_in)
      4'h0:    pattern = 7'h3f;
      4'h1:    pattern = 7'h06;
      4'h2:    pattern = 7'h5b;
      4'h3:    pattern = 7'h4f;
      4'h4:    pattern = 7'h66;
      4'h5:    pattern = 7'h6d;
      4'h6:    pattern = 7'h7d;
      4'h7:    pattern = 7'h07;
      4'h8:    pattern = 7'h7f;
      4'h9:    pattern = 7'h6f;
      default: pattern = 7'h00;
    endcase
  end

  // Registered, so the looked-up pattern reaches seg_out one clock after digit_in.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      seg_out <= 7'h00;
    end else begin
      seg_out <= pattern;
    end
  end

endmodule

// >>> sim/dsadc_seq_checker.sv
// Concurrent checks on phase timing, switch drive and display drive of the sequencer.
`timescale 1ns/100ps
module dsadc_seq_checker
  import dsadc_pkg::*;
#(
  parameter bit LCD_VARIANT = 1'b1  // Panel variant of the watched instance.
)(
  input wire logic       mclk_in,                 // Oscillator clock.
  input wire logic       reset_in,                // Synchronous reset.
  input wire logic       comparator_in,           // Comparator level.
  input wire logic       reading_freeze_input,    // Hold input.
  input wire logic       display_check_in,        // Display check input.
  input wire switch_type switches_out,            // Switch controls.
  input wire phase_type  phase_out,               // Current phase.
  input wire logic       reference_rundown_phase, // Rundown flag.
  input wire logic       panel_common_drive,      // Backplane.
  input wire logic       sign_indicator_output,   // Minus indicator.
  input wire logic       thousands_one_segments,  // Leading one.
  input wire logic [6:0] hundreds_seg_out,        // Hundreds segments.
  input wire logic [6:0] tens_seg_out,            // Tens segments.
  input wire logic [6:0] units_seg_out            // Units segments.
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  ////////////////////////////////////////////////////////////////////////////////
  // Phase lengths are counted in helper logic because they exceed any repetition.
  phase_type   prev_r;
  logic [15:0] cnt_r, cyc_r, bp_cnt_r;
  logic        seen_r, bp_r, bp_seen_r;
  logic        chg, entry, bp_chg;
  assign chg    = phase_out != prev_r;
  assign entry  = phase_out == PH_ACCUM && prev_r == PH_NULL;
  assign bp_chg = panel_common_drive != bp_r;

  // The first cycle after reset is short, so totals are judged from the second entry on.
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      prev_r    <= PH_NULL;
      cnt_r     <= 16'h0;
      cyc_r     <= 16'h0;
      seen_r    <= 1'b0;
      bp_r      <= 1'b0;
      bp_cnt_r  <= 16'h0;
      bp_seen_r <= 1'b0;
    end else begin
      prev_r    <= phase_out;
      cnt_r     <= chg ? 16'h1 : cnt_r + 16'h1;
      cyc_r     <= entry ? 16'h1 : cyc_r + 16'h1;
      seen_r    <= seen_r | entry;
      bp_r      <= panel_common_drive;
      bp_cnt_r  <= bp_chg ? 16'h1 : bp_cnt_r + 16'h1;
      bp_seen_r <= bp_seen_r | bp_chg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_phase_order: assert property (chg |-> (phase_out == PH_ACCUM && prev_r == PH_NULL) ||
    (phase_out == PH_RUNDOWN && prev_r == PH_ACCUM) || (phase_out == PH_NULL && prev_r == PH_RUNDOWN))
    else $error("phase order broken");
  a_accum_len: assert property (phase_out == PH_RUNDOWN && prev_r == PH_ACCUM |-> cnt_r == 16'hfa0)
    else $error("accumulate length wrong");
  a_rundown_len: assert property (phase_out == PH_NULL && prev_r == PH_RUNDOWN |->
    cnt_r >= 16'h4 && cnt_r <= 16'h1f40 && cnt_r[1:0] == 2'h0) else $error("rundown length wrong");
  a_null_len: assert property (entry && seen_r |-> cnt_r >= 16'hfa0 && cnt_r <= 16'h2ee0)
    else $error("offset-null length wrong");
  a_cycle_len: assert property (entry && seen_r |-> cyc_r == 16'h3e80)
    else $error("cycle length wrong");
  a_accum_switch: assert property (phase_out == PH_ACCUM |-> switches_out.inputs_connect &&
    !switches_out.inputs_short && !switches_out.null_loop) else $error("accumulate switches wrong");
  a_null_switch: assert property (phase_out == PH_NULL && prev_r == PH_RUNDOWN |->
    switches_out.inputs_short && switches_out.ref_charge && switches_out.null_loop)
    else $error("offset-null switches wrong");
  a_rundown_switch: assert property (phase_out == PH_RUNDOWN |-> reference_rundown_phase &&
    switches_out.low_to_common && (switches_out.ref_pos ^ switches_out.ref_neg))
    else $error("rundown switches wrong");
  a_ref_sign: assert property (phase_out == PH_RUNDOWN && prev_r == PH_ACCUM |->
    switches_out.ref_neg == $past(comparator_in)) else $error("reference polarity wrong");
  a_bp_period: assert property (bp_chg && bp_seen_r |-> bp_cnt_r == 16'h190)
    else $error("backplane half period wrong");
  a_led_nobp: assert property (!LCD_VARIANT |-> !panel_common_drive)
    else $error("backplane driven in LED variant");
  a_check_all: assert property (display_check_in [*3] |->
    {sign_indicator_output, thousands_one_segments, units_seg_out} ==
    (LCD_VARIANT ? {9{!panel_common_drive}} : 9'h1ff)) else $error("display check not all on");
  a_hold_stable: assert property ((reading_freeze_input && !display_check_in) [*4] |->
    $stable({sign_indicator_output, hundreds_seg_out, units_seg_out} ^ {15{panel_common_drive}}))
    else $error("display moved under hold");
endmodule

bind dsadc_seq dsadc_seq_checker #(.LCD_VARIANT(LCD_VARIANT)) chk (
  .mclk_in(mclk_in), .reset_in(reset_in), .comparator_in(comparator_in),
  .reading_freeze_input(reading_freeze_input), .display_check_in(display_check_in),
  .switches_out(switches_out), .phase_out(phase_out),
  .reference_rundown_phase(reference_rundown_phase), .panel_common_drive(panel_common_drive),
  .sign_indicator_output(sign_indicator_output), .thousands_one_segments(thousands_one_segments),
  .hundreds_seg_out(hundreds_seg_out), .tens_seg_out(tens_seg_out), .units_seg_out(units_seg_out));

// >>> sim/panel_model.sv
// Behavioural liquid-crystal panel that turns segment drive into lit segments.
`timescale 1ns/100ps
module panel_model (
  input  wire logic        common_in, // Backplane drive.
  input  wire logic [22:0] seg_in,    // Sign, thousands, hundreds, tens, units.
  output logic      [22:0] lit_out    // High where a segment shows.
);
  // A cell shows only while its drive differs from the backplane; DC never decides it.
  assign lit_out = seg_in ^ {23{common_in}};
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the converter sequencer with both panel variants.
`timescale 1ns/100ps
module tb_top
  import dsadc_pkg::*;
;
  logic        mclk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        comp = 1'b0;
  logic        hold = 1'b0;
  logic        dchk = 1'b0;
  switch_type  sw;
  phase_type   ph;
  logic        rrp, bp, sgn, th, bp2, sgn2, th2;
  logic [6:0]  hs, ts, us, hs2, ts2, us2;
  logic [22:0] lit;
  int          err_total = 0;
  int          n_compared = 0;

  typedef struct packed {
    logic c; logic [10:0] n; logic neg; logic th; logic [3:0] d2; logic [3:0] d1; logic [3:0] d0;
  } row_type;
  localparam logic [6:0] PAT [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                                      7'h7f, 7'h6f};
  // Comparator level at accumulate end, rundown ticks before the flip, expected reading.
  localparam row_type ROWS [4] = '{'{1'b1, 11'h0, 1'b0, 1'b0, 4'h0, 4'h0, 4'h0},
                                   '{1'b0, 11'h4d2, 1'b1, 1'b1, 4'h2, 4'h3, 4'h4},
                                   '{1'b1, 11'h61f, 1'b0, 1'b1, 4'h5, 4'h6, 4'h7},
                                   '{1'b0, 11'h7cf, 1'b1, 1'b1, 4'h9, 4'h9, 4'h9}};

  always #2 mclk_in = ~mclk_in;

  ////////////////////////////////////////////////////////////////////////////////
  dsadc_seq uut (.mclk_in(mclk_in), .reset_in(reset_in), .comparator_in(comp),
    .reading_freeze_input(hold), .display_check_in(dchk), .switches_out(sw), .phase_out(ph),
    .reference_rundown_phase(rrp), .panel_common_drive(bp), .sign_indicator_output(sgn),
    .thousands_one_segments(th), .hundreds_seg_out(hs), .tens_seg_out(ts), .units_seg_out(us));
  dsadc_seq #(.LCD_VARIANT(1'b0)) uut_led (.mclk_in(mclk_in), .reset_in(reset_in),
    .comparator_in(comp), .reading_freeze_input(hold), .display_check_in(dchk),
    .switches_out(), .phase_out(), .reference_rundown_phase(), .panel_common_drive(bp2),
    .sign_indicator_output(sgn2), .thousands_one_segments(th2), .hundreds_seg_out(hs2),
    .tens_seg_out(ts2), .units_seg_out(us2));
  panel_model pnl (.common_in(bp), .seg_in({sgn, th, hs, ts, us}), .lit_out(lit));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [22:0] exp_of(logic n, logic t, logic [3:0] a, logic [3:0] b,
                                         logic [3:0] d);
    return {n, t, PAT[a], PAT[b], PAT[d]};
  endfunction

  task automatic check(input string what, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", what, e, g);
      err_total++;
    end
  endtask

  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Bounded wait for a phase, counting falling edges so that lengths can be judged.
  task automatic wait_ph(input phase_type p, output int k);
    k = 0;
    while (ph !== p && k < 20000) begin
      @(negedge mclk_in);
      k++;
    end
    // A wait that runs out of its limit shows up here as a mismatch.
    check("phase reached", 34'(p), 34'(ph));
  endtask

  // One conversion: the comparator flips after n rundown ticks, so the reading is n.
  task automatic run(input logic c, input int n);
    int k;
    wait_ph(PH_ACCUM, k);
    comp = c;
    wait_ph(PH_RUNDOWN, k);
    check("accumulate clocks", 34'hfa0, 34'(k));
    repeat (4 * n) @(negedge mclk_in);
    comp = !c;
    wait_ph(PH_NULL, k);
    check("rundown clocks", 34'(4 * n + 4), 34'(4 * n + k));
    repeat (4) @(negedge mclk_in);
  endtask

  task automatic show(input logic [22:0] e);
    check("lit segments", 34'(e), 34'(lit));
    check("led segments", 34'(e), 34'({sgn2, th2, hs2, ts2, us2}));
    check("led common", 34'h0, 34'(bp2));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Runs the ordinary rows, then hold with display check, then a reset in mid-run.
  initial begin
    int k;
    repeat (20) @(negedge mclk_in);
    reset_in = 1'b0;
    check("phase after reset", 34'(PH_NULL), 34'(ph));
    for (int i = 0; i < 4; i++) begin
      run(ROWS[i].c, ROWS[i].n);
      show(exp_of(ROWS[i].neg, ROWS[i].th, ROWS[i].d2, ROWS[i].d1, ROWS[i].d0));
    end
    hold = 1'b1;
    dchk = 1'b1;
    run(1'b1, 11'h159);
    show(23'h7fffff);
    dchk = 1'b0;
    repeat (4) @(negedge mclk_in);
    show(exp_of(1'b1, 1'b1, 4'h9, 4'h9, 4'h9));
    hold = 1'b0;
    wait_ph(PH_ACCUM, k);
    reset_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    check("reset outputs", 34'h0, {sw, ph, rrp, bp, sgn, th, hs, ts, us});
    conclude;
  end

  // Five conversions plus the first short offset-null fit well inside this span.
  initial begin
    repeat (98000) @(posedge mclk_in);
    err_total++;
    conclude;
  end
endmodule
